// ==== aao_consts.svh ====
`ifndef AAO_CONSTS_SVH
`define AAO_CONSTS_SVH
// Operation
// - Add literal: accumulator plus literal into accumulator, updates carry, nibble carry, zero
// - AND literal: accumulator AND literal into accumulator, only zero flag updated
// - Add register: accumulator plus addressed register, all three flags updated
// - AND register: accumulator AND addressed register, only zero flag updated
// - Register forms: destination bit zero writes accumulator, one writes addressed register back
// - Literal forms: one cycle of four phases, accumulator written in last phase
// - Register forms: read in second phase, process third, write destination fourth
// - Reading the port register as source takes pin levels, not output latch

// Register byte offsets
`define AAO_OFS_INSTR 12'h000
`define AAO_OFS_ACC 12'h004
`define AAO_OFS_STATUS 12'h008
`define AAO_OFS_MEM_BASE 12'h200
`define AAO_MEM_SEL_BIT 9

// Status field positions
`define AAO_ST_C 0
`define AAO_ST_DC 1
`define AAO_ST_Z 2
`define AAO_ST_BUSY 8

// Instruction fields
`define AAO_INSTR_W 14
`define AAO_DEST_BIT 7
`define AAO_LIT_ADD_PFX 5'h1f
`define AAO_LIT_AND_OP 6'h39
`define AAO_REG_ADD_OP 6'h07
`define AAO_REG_AND_OP 6'h05

// Reset values and port register index
`define AAO_RST_ACC 8'h00
`define AAO_RST_INSTR 14'h0000
`define AAO_PORT_IDX 7'h06
`endif

// ==== aao_pkg.sv ====
package aao_pkg;
    typedef enum logic [2:0] {
        AAO_IDLE = 3'b000,
        AAO_Q1 = 3'b001,
        AAO_Q2 = 3'b010,
        AAO_Q3 = 3'b011,
        AAO_Q4 = 3'b100
    } aao_phase_t;

    typedef enum logic [2:0] {
        AAO_OP_NOP = 3'b000,
        AAO_OP_ADD_LIT = 3'b001,
        AAO_OP_AND_LIT = 3'b010,
        AAO_OP_ADD_REG = 3'b011,
        AAO_OP_AND_REG = 3'b100
    } aao_op_t;

    typedef struct packed {
        logic z;
        logic dc;
        logic c;
    } aao_flags_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
    } aao_bus_req_t;
endpackage

// ==== aao_core.sv ====
`timescale 1ns/100ps
`include "aao_consts.svh"

module aao_core
    import aao_pkg::*;
#(
    parameter int MEM_DEPTH = 128,
    parameter int PORT_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Port pins
    input wire logic [PORT_W-1:0] port_pins,
    output logic [PORT_W-1:0] port_latch,
    // Core state
    output logic busy,
    output logic [2:0] phase
);

    ////////////////////////////////////////////////////////////////////////
    // State

    aao_phase_t state;
    aao_phase_t next_state;
    aao_op_t op;
    aao_op_t next_op;
    logic [`AAO_INSTR_W-1:0] instr;
    logic [`AAO_INSTR_W-1:0] next_instr;
    logic [7:0] acc;
    logic [7:0] next_acc;
    aao_flags_t flags;
    aao_flags_t next_flags;
    logic [7:0] operand;
    logic [7:0] next_operand;
    logic [7:0] result;
    logic [7:0] next_result;
    aao_flags_t res_flags;
    aao_flags_t next_res_flags;
    logic [7:0] mem [MEM_DEPTH];
    logic [7:0] next_mem [MEM_DEPTH];
    aao_bus_req_t req;
    aao_bus_req_t next_req;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [PORT_W-1:0] next_port_latch;

    logic [6:0] fidx;
    logic dest_reg;
    logic [8:0] sum;
    logic [4:0] low_sum;
    logic [6:0] bus_idx;
    logic [6:0] rd_idx;

    assign fidx = instr[6:0];
    assign dest_reg = instr[`AAO_DEST_BIT];
    assign bus_idx = req.addr[8:2];
    assign rd_idx = haddr[8:2];

    ////////////////////////////////////////////////////////////////////////
    // Bus and execution next values

    always_comb begin
        next_state = state;
        next_op = op;
        next_instr = instr;
        next_acc = acc;
        next_flags = flags;
        next_operand = operand;
        next_result = result;
        next_res_flags = res_flags;
        next_mem = mem;
        next_req = req;
        next_rdata = rdata;
        sum = 9'h000;
        low_sum = 5'h00;

        // Bus address phase capture
        next_req.valid = hsel && htrans[1] && hready;
        next_req.write = hwrite;
        next_req.addr = haddr[11:0];

        // Bus data phase write
        if (req.valid && req.write) begin
            if (req.addr == `AAO_OFS_INSTR) begin
                if (state == AAO_IDLE) begin
                    next_instr = hwdata[`AAO_INSTR_W-1:0];
                    next_state = AAO_Q1;
                end
            end else if (req.addr == `AAO_OFS_ACC) begin
                if (state == AAO_IDLE) begin
                    next_acc = hwdata[7:0];
                end
            end else if (req.addr == `AAO_OFS_STATUS) begin
                if (state == AAO_IDLE) begin
                    next_flags.c = hwdata[`AAO_ST_C];
                    next_flags.dc = hwdata[`AAO_ST_DC];
                    next_flags.z = hwdata[`AAO_ST_Z];
                end
            end else if (req.addr[11:`AAO_MEM_SEL_BIT + 1] == 2'b00 && req.addr[`AAO_MEM_SEL_BIT]) begin
                if (state == AAO_IDLE && 32'(bus_idx) < MEM_DEPTH) begin
                    next_mem[bus_idx] = hwdata[7:0];
                end
            end
        end

        // Bus read data, taken in the address phase
        if (hsel && htrans[1] && hready && !hwrite) begin
            next_rdata = 32'h0000_0000;
            if (haddr[11:0] == `AAO_OFS_INSTR) begin
                next_rdata[`AAO_INSTR_W-1:0] = instr;
            end else if (haddr[11:0] == `AAO_OFS_ACC) begin
                next_rdata[7:0] = acc;
            end else if (haddr[11:0] == `AAO_OFS_STATUS) begin
                next_rdata[`AAO_ST_C] = flags.c;
                next_rdata[`AAO_ST_DC] = flags.dc;
                next_rdata[`AAO_ST_Z] = flags.z;
                next_rdata[`AAO_ST_BUSY] = (state != AAO_IDLE);
            end else if (haddr[11:`AAO_MEM_SEL_BIT + 1] == 2'b00 && haddr[`AAO_MEM_SEL_BIT]) begin
                if (32'(rd_idx) < MEM_DEPTH) begin
                    next_rdata[7:0] = mem[rd_idx];
                end
            end
        end

        // Instruction phases
        case (state)
            AAO_IDLE: begin
                next_state = next_state;
            end
            AAO_Q1: begin
                if (instr[13:9] == `AAO_LIT_ADD_PFX) begin
                    next_op = AAO_OP_ADD_LIT;
                end else if (instr[13:8] == `AAO_LIT_AND_OP) begin
                    next_op = AAO_OP_AND_LIT;
                end else if (instr[13:8] == `AAO_REG_ADD_OP) begin
                    next_op = AAO_OP_ADD_REG;
                end else if (instr[13:8] == `AAO_REG_AND_OP) begin
                    next_op = AAO_OP_AND_REG;
                end else begin
                    next_op = AAO_OP_NOP;
                end
                next_state = AAO_Q2;
            end
            AAO_Q2: begin
                if (op == AAO_OP_ADD_LIT || op == AAO_OP_AND_LIT) begin
                    next_operand = instr[7:0];
                end else if (fidx == `AAO_PORT_IDX) begin
                    next_operand = 8'(port_pins);
                end else if (32'(fidx) < MEM_DEPTH) begin
                    next_operand = mem[fidx];
                end else begin
                    next_operand = 8'h00;
                end
                next_state = AAO_Q3;
            end
            AAO_Q3: begin
                sum = {1'b0, acc} + {1'b0, operand};
                low_sum = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
                next_res_flags = flags;
                if (op == AAO_OP_ADD_LIT || op == AAO_OP_ADD_REG) begin
                    next_result = sum[7:0];
                    next_res_flags.c = sum[8];
                    next_res_flags.dc = low_sum[4];
                end else begin
                    next_result = acc & operand;
                end
                next_res_flags.z = (op == AAO_OP_ADD_LIT || op == AAO_OP_ADD_REG) ?
                    (sum[7:0] == 8'h00) : ((acc & operand) == 8'h00);
                next_state = AAO_Q4;
            end
            AAO_Q4: begin
                if (op != AAO_OP_NOP) begin
                    next_flags = res_flags;
                    if ((op == AAO_OP_ADD_REG || op == AAO_OP_AND_REG) && dest_reg) begin
                        if (32'(fidx) < MEM_DEPTH) begin
                            next_mem[fidx] = result;
                        end
                    end else begin
                        next_acc = result;
                    end
                end
                next_state = AAO_IDLE;
            end
            default: begin
                next_state = AAO_IDLE;
            end
        endcase

        next_port_latch = PORT_W'(next_mem[`AAO_PORT_IDX]);
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= AAO_IDLE;
            op <= AAO_OP_NOP;
            instr <= `AAO_RST_INSTR;
            acc <= `AAO_RST_ACC;
            flags <= '0;
            operand <= 8'h00;
            result <= 8'h00;
            res_flags <= '0;
            req <= '0;
            rdata <= 32'h0000_0000;
            port_latch <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            busy <= 1'b0;
            phase <= 3'h0;
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem[i] <= 8'h00;
            end
        end else begin
            state <= next_state;
            op <= next_op;
            instr <= next_instr;
            acc <= next_acc;
            flags <= next_flags;
            operand <= next_operand;
            result <= next_result;
            res_flags <= next_res_flags;
            req <= next_req;
            rdata <= next_rdata;
            port_latch <= next_port_latch;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            busy <= (next_state != AAO_IDLE);
            phase <= next_state;
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem[i] <= next_mem[i];
            end
        end
    end

    assign hrdata = rdata;

endmodule

// ==== aao_chk_asserts.sv ====
`timescale 1ns/100ps
module aao_chk
    import aao_pkg::*;
#(
    parameter int PORT_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus side
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Core side
    input wire logic [PORT_W-1:0] port_latch,
    input wire logic busy,
    input wire logic [2:0] phase
);
    wire logic go = hsel && htrans[1] && hready && hwrite && haddr[11:0] == 12'h000;
    wire logic rd = hsel && htrans[1] && hready && !hwrite;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    a_phase_walk: assert property (phase == 3'd1 |=> phase == 3'd2 ##1 phase == 3'd3 ##1 phase == 3'd4 ##1 phase == 3'd0)
        else $error("phase order broken");
    a_busy_phase: assert property (busy == (phase != 3'd0))
        else $error("busy disagrees with phase");
    a_busy_len: assert property ($rose(busy) |-> busy [*4] ##1 !busy)
        else $error("busy not four cycles");
    a_start_run: assert property (go && !busy |=> ##1 phase == 3'd1)
        else $error("instruction did not start");
    a_quiet_idle: assert property (!busy && !go && !$past(go) |=> !busy)
        else $error("busy without instruction");
    a_latch_hold: assert property (phase != 3'd0 && phase != 3'd4 |=> $stable(port_latch))
        else $error("latch written before last phase");
    a_rdata_hold: assert property (!rd |=> $stable(hrdata))
        else $error("read data moved without read");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or error");
    c_last_phase: cover property (phase == 3'd4);
    c_read: cover property (rd);
    c_latch: cover property ($changed(port_latch));
endmodule
bind aao_core aao_chk #(.PORT_W(PORT_W)) aao_chk_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .port_latch(port_latch), .busy(busy), .phase(phase));

// ==== aao_pins.sv ====
`timescale 1ns/100ps
module aao_pins (
    // Latch and outside pull
    input wire logic [7:0] port_latch,
    input wire logic [7:0] pull_mask,
    // Pin levels
    output logic [7:0] port_pins
);
    // Outside devices flip masked pins
    assign port_pins = port_latch ^ pull_mask;
endmodule

// ==== add_and_accumulator_ops_test.sv ====
`timescale 1ns/100ps
module add_and_accumulator_ops_test;
    import aao_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, q;
    logic hreadyout, hresp, busy;
    logic [2:0] phase;
    logic [2:0] fl = 3'h0;
    logic [7:0] pins, latch, acc;
    logic [7:0] mask = 8'h00;
    logic [7:0] mem [128];
    logic [31:0] rng = 32'haaafbf66;
    int fail_count = 0;
    int check_count = 0;
    always #2.5 clk = ~clk;
    aao_core aao_core_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .port_pins(pins), .port_latch(latch), .busy(busy), .phase(phase));
    aao_pins aao_pins_inst (.port_latch(latch), .pull_mask(mask), .port_pins(pins));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    // Expected flags and result of one operation
    function automatic logic [10:0] model(input logic add, input logic [7:0] a, input logic [7:0] s,
        input logic [2:0] f);
        logic [8:0] r;
        logic [2:0] g;
        g = f;
        r = add ? {1'b0, a} + {1'b0, s} : {1'b0, a & s};
        if (add) g = {r[7:0] == 8'h0, a[4] ^ s[4] ^ r[4], r[8]};
        else g[2] = r[7:0] == 8'h0;
        return {g, r[7:0]};
    endfunction
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic exec(input logic [13:0] i);
        logic [10:0] m;
        logic [7:0] src;
        logic add, andop, d;
        // Let a new pull mask settle before it is used
        @(posedge clk);
        add = i[13:9] == 5'h1f || i[13:8] == 6'h07;
        andop = i[13:8] == 6'h39 || i[13:8] == 6'h05;
        d = i[7] && !i[13];
        src = i[13] ? i[7:0] : (i[6:0] == 7'h06 ? mem[6] ^ mask : mem[i[6:0]]);
        m = model(add, acc, src, fl);
        if (add || andop) begin
            fl = m[10:8];
            if (d) mem[i[6:0]] = m[7:0];
            else acc = m[7:0];
        end
        bus(1'b1, 12'h000, {18'h0, i}, q);
        repeat (2) @(posedge clk);
        #1;
        check("busy", {31'h0, busy}, 32'h1);
        check("phase", {29'h0, phase}, 32'h3);
        while (busy !== 1'b0) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        bus(1'b0, 12'h004, 32'h0, q);
        check("acc", q, {24'h0, acc});
        bus(1'b0, 12'h008, 32'h0, q);
        check("status", q, {29'h0, fl});
        bus(1'b0, 12'h200 + {3'h0, i[6:0], 2'h0}, 32'h0, q);
        if (i[6:0] != 7'h06) check("mem", q, {24'h0, mem[i[6:0]]});
        check("latch", {24'h0, latch}, {24'h0, mem[6]});
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [5:0] opc [6] = '{6'h3e, 6'h3f, 6'h39, 6'h07, 6'h05, 6'h3a};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int k = 0; k < 128; k++) begin
            mem[k] = 8'(rnd());
            bus(1'b1, 12'h200 + 12'(k * 4), {24'h0, mem[k]}, q);
        end
        bus(1'b1, 12'h004, 32'h10, q);
        acc = 8'h10;
        bus(1'b0, 12'h100, 32'h0, q);
        check("unmapped", q, 32'h0);
        // Status written while idle, read back after one idle cycle
        bus(1'b1, 12'h008, 32'h7, q);
        fl = 3'h7;
        @(posedge clk);
        bus(1'b0, 12'h008, 32'h0, q);
        check("status", q, 32'h7);
        // Unknown opcode changes nothing, writes while busy are dropped
        bus(1'b1, 12'h000, 32'h3a00, q);
        bus(1'b1, 12'h004, 32'hff, q);
        repeat (4) @(posedge clk);
        bus(1'b0, 12'h000, 32'h0, q);
        check("instr", q, 32'h3a00);
        bus(1'b0, 12'h004, 32'h0, q);
        check("refused", q, {24'h0, acc});
        bus(1'b0, 12'h008, 32'h0, q);
        check("nop status", q, 32'h7);
        // Corner sums and port source
        exec(14'h3f15);
        exec(14'h3edb);
        exec(14'h395f);
        mask <= 8'h5a;
        exec(14'h0786);
        exec(14'h0506);
        $display("corner test done");
        for (int n = 0; n < 60; n++) begin
            q = rnd();
            mask <= q[23:16];
            exec({opc[q[31:29] % 3'd6], q[15], q[26] ? 7'h06 : q[14:8]});
        end
        $display("random test done");
        complete_run();
    end
    initial begin
        #100000;
        fail_count++;
        complete_run();
    end
endmodule
